/* hdl/dsr_serial_readout.sv */
// Conversion sequencing, offset calibration and serial readout of two converters
`timescale 1ns/1ps
`default_nettype none
module dsr_serial_readout
  import dsr_pkg::*;
(
  input wire logic clock, // System clock, 40 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic sclk, // Serial and conversion clock from host
  input wire logic csN, // Chip-select pin, active low
  input wire logic calPin, // Calibration request pin
  input wire logic [11:0] controlWord, // Control word image
  input wire logic [13:0] rawFirst, // First converter code
  input wire logic [13:0] rawSecond, // Second converter code
  input wire logic offsetWrite, // Offset register write strobe
  input wire logic [3:0] registerSelectField, // Register select field
  input wire logic [11:0] offsetData, // Offset write data
  output logic holdActive, // Samplers in hold
  output logic shortInputs, // Inputs shorted for calibration
  output logic resultCorrupt, // Current result corrupted
  output logic calInaccurate, // Calibration setup was short
  output logic [11:0] offsetFirst, // Stored first offset
  output logic [11:0] offsetSecond, // Stored second offset
  output logic serialOutFirst, // First data line
  output logic serialOutFirstOeN, // First line enable, low drives
  output logic serialOutSecond, // Second data line
  output logic serialOutSecondOeN // Second line enable, low drives
);
  // System domain state
  logic csS1, csS2, csPrev, calS1, calS2, calPrev, doneS1, doneS2, donePrev;
  logic next_csPrev, next_calPrev, next_donePrev;
  logic calRun, next_calRun, corrupt, next_corrupt, inacc, next_inacc;
  logic computeStep, next_computeStep, wordsReady, next_wordsReady;
  logic [7:0] setupCnt, next_setupCnt;
  logic [13:0] capRaw [NUM_CH];
  logic [13:0] next_capRaw [NUM_CH];
  logic [13:0] resWord [NUM_CH];
  logic [13:0] next_resWord [NUM_CH];
  logic [11:0] offset [NUM_CH];
  logic [11:0] next_offset [NUM_CH];
  logic [13:0] corr [NUM_CH];
  logic [11:0] calCode [NUM_CH];
  logic [13:0] rawIn [NUM_CH];
  logic csFall, doneRise;

  // Link domain state
  logic [5:0] count, next_count;
  logic drive, next_drive, convDone, next_convDone, rdyS1, rdyS2;
  logic [SHIFT_W-1:0] shiftFirst, next_shiftFirst, shiftSecond, next_shiftSecond;

  assign rawIn[0] = rawFirst;
  assign rawIn[1] = rawSecond;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_ch
      dsr_offset_fix u_fix (
        .raw(capRaw[ch]),
        .ofs(offset[ch]),
        .corr(corr[ch]),
        .calCode(calCode[ch])
      );
    end
  endgenerate

  always_ff @(posedge clock)
  begin
    csS1 <= csN;
    csS2 <= csS1;
    calS1 <= calPin;
    calS2 <= calS1;
    doneS1 <= convDone;
    doneS2 <= doneS1;
  end

  assign csFall = csPrev & ~csS2;
  assign doneRise = doneS2 & ~donePrev;

  always_comb
  begin
    next_csPrev = csS2;
    next_calPrev = calS2;
    next_donePrev = doneS2;
    next_calRun = calRun;
    next_corrupt = corrupt;
    next_inacc = inacc;
    next_computeStep = 1'b0;
    next_wordsReady = wordsReady & ~csS2;
    next_capRaw = capRaw;
    next_resWord = resWord;
    next_offset = offset;
    next_setupCnt = calS2 ? ((setupCnt == TRIM_SETUP_CYC) ? setupCnt : setupCnt + 8'h01) : 8'h00;
    if (csFall)
    begin
      next_capRaw = rawIn;
      // Pin level or control bit decides afresh at each chip-select fall
      next_calRun = calS2 | controlWord[CAL_BIT_POS];
      next_corrupt = controlWord[CAL_BIT_POS];
      next_inacc = calS2 & (setupCnt < TRIM_SETUP_CYC);
      next_computeStep = 1'b1;
      next_wordsReady = 1'b0;
    end
    if (computeStep)
    begin
      next_resWord = corr;
      next_wordsReady = 1'b1;
    end
    if (~csS2 & ~doneS2 & calS2 & ~calPrev & ~csFall)
      next_corrupt = 1'b1;
    if (offsetWrite)
    begin
      if (registerSelectField == SEL_OFS_FIRST)
        next_offset[0] = offsetData;
      if (registerSelectField == SEL_OFS_SECOND)
        next_offset[1] = offsetData;
    end
    // Calibration store wins over a manual write in the same cycle
    if (doneRise & calRun)
    begin
      next_offset = calCode;
      next_calRun = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      csPrev <= 1'b1;
      calPrev <= 1'b0;
      donePrev <= 1'b0;
      calRun <= 1'b0;
      corrupt <= 1'b0;
      inacc <= 1'b0;
      computeStep <= 1'b0;
      wordsReady <= 1'b0;
      setupCnt <= 8'h00;
      capRaw <= '{default: RES_RESET};
      resWord <= '{default: RES_RESET};
      offset <= '{default: OFS_RESET};
    end
    else
    begin
      csPrev <= next_csPrev;
      calPrev <= next_calPrev;
      donePrev <= next_donePrev;
      calRun <= next_calRun;
      corrupt <= next_corrupt;
      inacc <= next_inacc;
      computeStep <= next_computeStep;
      wordsReady <= next_wordsReady;
      setupCnt <= next_setupCnt;
      capRaw <= next_capRaw;
      resWord <= next_resWord;
      offset <= next_offset;
    end
  end

  assign shortInputs = calRun;
  assign resultCorrupt = corrupt;
  assign calInaccurate = inacc;
  assign offsetFirst = offset[0];
  assign offsetSecond = offset[1];
  // Pin-level path so hold ends on edge 19 and starts at the pin fall
  assign holdActive = ~csN & ~convDone;

  // Link domain: chip-select high is its reset, so nothing depends on sclk
  // running outside a frame
  always_ff @(negedge sclk or posedge csN)
  begin
    if (csN)
    begin
      rdyS1 <= 1'b0;
      rdyS2 <= 1'b0;
    end
    else
    begin
      rdyS1 <= wordsReady;
      rdyS2 <= rdyS1;
    end
  end

  always_comb
  begin
    next_count = (count == EDGE_SINGLE_END) ? count : count + 6'h01;
    next_convDone = convDone;
    next_drive = drive;
    next_shiftFirst = shiftFirst;
    next_shiftSecond = shiftSecond;
    if (next_count == EDGE_CONV_DONE)
    begin
      next_convDone = 1'b1;
      next_drive = 1'b1;
      // Words are stable once ready is seen; else the line shows zeros
      next_shiftFirst = rdyS2 ? {resWord[0], resWord[1]} : '0;
      next_shiftSecond = rdyS2 ? {resWord[1], resWord[0]} : '0;
    end
    else if (drive)
    begin
      next_shiftFirst = {shiftFirst[SHIFT_W-2:0], 1'b0};
      next_shiftSecond = {shiftSecond[SHIFT_W-2:0], 1'b0};
      if (next_count == EDGE_SINGLE_END)
        next_drive = 1'b0;
    end
  end

  always_ff @(negedge sclk or posedge csN)
  begin
    if (csN)
    begin
      count <= 6'h00;
      convDone <= 1'b0;
      drive <= 1'b0;
      shiftFirst <= '0;
      shiftSecond <= '0;
    end
    else
    begin
      count <= next_count;
      convDone <= next_convDone;
      drive <= next_drive;
      shiftFirst <= next_shiftFirst;
      shiftSecond <= next_shiftSecond;
    end
  end

  assign serialOutFirst = shiftFirst[SHIFT_W-1];
  assign serialOutSecond = shiftSecond[SHIFT_W-1];
  assign serialOutFirstOeN = ~drive;
  assign serialOutSecondOeN = ~drive;

  sequence s_frame_loaded;
    (count == EDGE_CONV_DONE) ##1 (count == EDGE_CONV_DONE + 6'h01);
  endsequence

  a_hiz_conversion: assert property (@(negedge sclk) disable iff (csN)
    (count < EDGE_CONV_DONE) |-> (serialOutFirstOeN && serialOutSecondOeN))
    else $error("data line driven during conversion");
  a_drive_edge19: assert property (@(negedge sclk) disable iff (csN)
    (count == EDGE_CONV_DONE) |-> (!serialOutFirstOeN && !serialOutSecondOeN && !holdActive))
    else $error("drivers not enabled at edge 19");
  a_msb_first: assert property (@(negedge sclk) disable iff (csN)
    (count == EDGE_CONV_DONE) && rdyS2 |-> (serialOutFirst == resWord[0][13]) && (serialOutSecond == resWord[1][13]))
    else $error("first bit is not the result MSB");
  a_bit_order: assert property (@(negedge sclk) disable iff (csN)
    s_frame_loaded |-> (serialOutFirst == $past(shiftFirst[SHIFT_W-2])))
    else $error("second bit out of order");
  a_other_result: assert property (@(negedge sclk) disable iff (csN)
    (count == EDGE_LAST_READ) && rdyS2 |-> (serialOutFirst == resWord[1][13]) && (serialOutSecond == resWord[0][13]))
    else $error("other result does not follow");
  a_float_edge47: assert property (@(posedge sclk) disable iff (csN)
    (count == EDGE_SINGLE_END) |-> serialOutFirstOeN && serialOutSecondOeN)
    else $error("line still driven at edge 47");
  a_count_step: assert property (@(negedge sclk) disable iff (csN)
    (count != 6'h00) && ($past(count) != EDGE_SINGLE_END) |-> (count == $past(count) + 6'h01))
    else $error("edge counter skipped");
  a_cs_release: assert property (@(posedge clock) disable iff (rst)
    csS2 |-> serialOutFirstOeN && serialOutSecondOeN)
    else $error("line driven with chip-select high");
  a_cal_start: assert property (@(posedge clock) disable iff (rst)
    csFall && calS2 |=> calRun ##1 shortInputs)
    else $error("calibration not started by pin");
  a_cal_bit: assert property (@(posedge clock) disable iff (rst)
    csFall && controlWord[CAL_BIT_POS] |=> calRun && resultCorrupt)
    else $error("control bit did not start calibration");
  a_offset_store: assert property (@(posedge clock) disable iff (rst)
    doneRise && calRun |=> (offsetFirst == $past(calCode[0])) && (offsetSecond == $past(calCode[1])) && !calRun)
    else $error("offset not stored at calibration end");
  a_sample_hold: assert property (@(posedge clock) disable iff (rst)
    csFall |=> (capRaw[0] == $past(rawFirst)) ##1 wordsReady && (resWord[0] == $past(corr[0])))
    else $error("sample not captured at chip-select fall");
endmodule
`default_nettype wire

/* hdl/dsr_pkg.sv */
// Constants shared by the dual converter serial readout block
package dsr_pkg;
  localparam int RES_W = 14;
  localparam int OFS_W = 12;
  localparam int NUM_CH = 2;
  localparam int SHIFT_W = 2 * RES_W;
  localparam int CAL_BIT_POS = 7;
  localparam logic [5:0] EDGE_CONV_DONE = 6'h13;
  localparam logic [5:0] EDGE_LSB = 6'h20;
  localparam logic [5:0] EDGE_LAST_READ = 6'h21;
  localparam logic [5:0] EDGE_SINGLE_END = 6'h2F;
  localparam logic [3:0] SEL_OFS_FIRST = 4'h2;
  localparam logic [3:0] SEL_OFS_SECOND = 4'h3;
  localparam logic [11:0] OFS_RESET = 12'h000;
  localparam logic [13:0] RES_RESET = 14'h0000;
  localparam int OFS_RANGE = 500;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TRIM_REQUEST_SETUP_TIME_NS = 100;
  localparam logic [7:0] TRIM_SETUP_CYC =
    8'((TRIM_REQUEST_SETUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
endpackage

/* hdl/dsr_offset_fix.sv */
// Offset subtraction and offset code forming for one converter
`timescale 1ns/1ps
`default_nettype none
module dsr_offset_fix
  import dsr_pkg::*;
(
  input wire logic [13:0] raw, // Two's complement conversion code
  input wire logic [11:0] ofs, // Stored offset, sign and magnitude
  output logic [13:0] corr, // Corrected code, saturated
  output logic [11:0] calCode // Raw code as an offset value
);
  logic signed [15:0] rawExt;
  logic signed [15:0] ofsExt;
  logic signed [15:0] diff;
  logic [14:0] absRaw;

  always_comb
  begin
    rawExt = {{2{raw[13]}}, raw};
    ofsExt = {5'h00, ofs[10:0]};
    // Full 11-bit magnitude covers the needed offset range with margin
    diff = ofs[11] ? rawExt + ofsExt : rawExt - ofsExt;
    if (diff > 16'sh1FFF)
      corr = 14'h1FFF;
    else if (diff < -16'sh2000)
      corr = 14'h2000;
    else
      corr = diff[13:0];
    absRaw = raw[13] ? 15'(-{raw[13], raw}) : {1'h0, raw};
    calCode = {raw[13], (absRaw > 15'h07FF) ? 11'h7FF : absRaw[10:0]};
  end
endmodule
`default_nettype wire

/* testbench/dsr_host_model.sv */
// Host serial port model: frames chip-select and serial clock, captures both lines
`timescale 1ns/1ps
`default_nettype none
module dsr_host_model (
  output logic sclk, // Serial clock, idles high
  output logic csN, // Chip-select, active low
  input wire logic dataFirst, // First data line
  input wire logic oeFirstN, // First line enable, low drives
  input wire logic dataSecond, // Second data line
  input wire logic oeSecondN // Second line enable, low drives
);
  logic lastFirst;
  logic lastSecond;
  initial
  begin
    sclk = 1'b1;
    lastFirst = 1'b0;
    lastSecond = 1'b0;
    // Late first edge so the link flops see a clear even if they start after time zero
    #1;
    csN = 1'b1;
  end
  // Clock stands still outside frames; a floating line reads inverted so stale bits never pass
  task automatic frame(input int edges, output logic [27:0] wFirst, output logic [27:0] wSecond,
                       output logic [47:0] fFirst, output logic [47:0] fSecond);
    wFirst = '0;
    wSecond = '0;
    fFirst = '1;
    fSecond = '1;
    csN = 1'b0;
    #80;
    for (int k = 1; k <= edges; k++)
    begin
      sclk = 1'b0;
      #80;
      // Late in the low phase, so it also stands for a rising-edge reader
      fFirst[k] = oeFirstN;
      fSecond[k] = oeSecondN;
      lastFirst = oeFirstN ? ~lastFirst : dataFirst;
      lastSecond = oeSecondN ? ~lastSecond : dataSecond;
      if (k >= 19 && k <= 46)
      begin
        wFirst = {wFirst[26:0], lastFirst};
        wSecond = {wSecond[26:0], lastSecond};
      end
      sclk = 1'b1;
      #80;
    end
    csN = 1'b1;
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the dual converter serial readout
`timescale 1ns/1ps
`default_nettype none
module testbench import dsr_pkg::*;;
  logic clock = 1'b0, rst = 1'b1, calPin = 1'b0, offsetWrite = 1'b0;
  logic [11:0] controlWord = 12'h000, offsetData = 12'h000, oa, ob;
  logic [3:0] registerSelectField = 4'h0;
  logic [13:0] rawFirst = 14'h0000, rawSecond = 14'h0000, mean;
  logic holdActive, shortInputs, resultCorrupt, calInaccurate, sclk, csN;
  logic [11:0] offsetFirst, offsetSecond;
  logic serialOutFirst, serialOutFirstOeN, serialOutSecond, serialOutSecondOeN;
  logic [31:0] seed = 32'h000004E0;
  int errors = 0, total_checks = 0;
  always #12.5 clock = ~clock;
  dsr_serial_readout dsr_serial_readout_i (.clock(clock), .rst(rst), .sclk(sclk), .csN(csN),
    .calPin(calPin), .controlWord(controlWord), .rawFirst(rawFirst), .rawSecond(rawSecond),
    .offsetWrite(offsetWrite), .registerSelectField(registerSelectField), .offsetData(offsetData),
    .holdActive(holdActive), .shortInputs(shortInputs), .resultCorrupt(resultCorrupt),
    .calInaccurate(calInaccurate), .offsetFirst(offsetFirst), .offsetSecond(offsetSecond),
    .serialOutFirst(serialOutFirst), .serialOutFirstOeN(serialOutFirstOeN),
    .serialOutSecond(serialOutSecond), .serialOutSecondOeN(serialOutSecondOeN));
  dsr_host_model dsr_host_model_i (.sclk(sclk), .csN(csN), .dataFirst(serialOutFirst),
    .oeFirstN(serialOutFirstOeN), .dataSecond(serialOutSecond), .oeSecondN(serialOutSecondOeN));
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Sign-magnitude offset off a two's complement code, clipped to 14 bits
  function automatic logic [13:0] corr(input logic [13:0] raw, input logic [11:0] ofs);
    int v;
    v = int'($signed(raw)) - (ofs[11] ? -int'(ofs[10:0]) : int'(ofs[10:0]));
    if (v > 8191) v = 8191;
    if (v < -8192) v = -8192;
    return v[13:0];
  endfunction
  function automatic logic [11:0] calc(input logic [13:0] raw);
    int m;
    m = int'($signed(raw));
    if (m < 0) m = -m;
    if (m > 2047) m = 2047;
    return {raw[13], m[10:0]};
  endfunction
  task automatic check(input logic [95:0] got, input logic [95:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Falling edges seen in the current frame, for the hold check
  int falls = 0;
  always @(negedge sclk or posedge csN)
    if (csN)
      falls <= 0;
    else
      falls <= falls + 1;
  always @(posedge sclk)
    if (!csN)
      check(96'(holdActive), 96'(falls < int'(EDGE_CONV_DONE)), "hold");
  task automatic write_ofs(input logic [3:0] sel, input logic [11:0] d);
    @(negedge clock);
    offsetWrite = 1'b1;
    registerSelectField = sel;
    offsetData = d;
    @(negedge clock);
    offsetWrite = 1'b0;
  endtask
  task automatic run_frame(input int edges);
    logic [27:0] wa, wb, fa, fb;
    logic [47:0] pa, pb, pe;
    int m;
    @(negedge clock);
    rawFirst = 14'(xorshift());
    rawSecond = 14'(xorshift());
    fa = {corr(rawFirst, oa), corr(rawSecond, ob)};
    fb = {fa[13:0], fa[27:14]};
    m = (edges > 46 ? 46 : edges) - 18;
    pe = '1;
    for (int k = 19; k <= 46 && k <= edges; k++) pe[k] = 1'b0;
    dsr_host_model_i.frame(edges, wa, wb, pa, pb);
    #1;
    check(96'(wa), 96'(fa >> (28 - m)), "first line");
    check(96'(wb), 96'(fb >> (28 - m)), "second line");
    check({pa, pb}, {pe, pe}, "enables");
    check(96'({serialOutFirstOeN, serialOutSecondOeN}), 96'(2'b11), "release");
    repeat (6) @(negedge clock);
  endtask
  initial
  begin
    #500us;
    errors++;
    close_out();
  end
  initial
  begin
    oa = 12'h000;
    ob = 12'h000;
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    check(96'({offsetFirst, offsetSecond, shortInputs, resultCorrupt}), 96'(0), "reset");
    for (int i = 0; i < 5; i++)
      run_frame(i == 4 ? 20 + int'(xorshift() % 28) : 47 - 7 * i);
    // Manual loads, first at a random value up to the correction limit, second at the limit; unmapped select must be ignored
    mean = 14'(xorshift() % (OFS_RANGE + 1));
    oa = {mean[13], mean[10:0]};
    write_ofs(SEL_OFS_FIRST, oa);
    ob = 12'h9F4;
    write_ofs(SEL_OFS_SECOND, ob);
    write_ofs(4'h4, 12'h555);
    check(96'({offsetFirst, offsetSecond}), 96'({oa, ob}), "offset load");
    run_frame(47);
    calPin = 1'b1;
    run_frame(47);
    check(96'(calInaccurate), 96'(1), "short setup");
    oa = calc(rawFirst);
    ob = calc(rawSecond);
    check(96'({offsetFirst, offsetSecond}), 96'({oa, ob}), "cal store");
    run_frame(33);
    check(96'(calInaccurate), 96'(0), "setup met");
    oa = calc(rawFirst);
    ob = calc(rawSecond);
    check(96'({offsetFirst, offsetSecond}), 96'({oa, ob}), "recal");
    calPin = 1'b0;
    run_frame(47);
    check(96'({offsetFirst, offsetSecond, shortInputs}), 96'({oa, ob, 1'b0}), "kept");
    controlWord[CAL_BIT_POS] = 1'b1;
    run_frame(40);
    check(96'(resultCorrupt), 96'(1), "cal bit");
    oa = calc(rawFirst);
    ob = calc(rawSecond);
    check(96'({offsetFirst, offsetSecond}), 96'({oa, ob}), "bit cal");
    controlWord = 12'h000;
    run_frame(47);
    check(96'(resultCorrupt), 96'(0), "normal");
    // Request raised well inside this frame's conversion
    fork
      run_frame(33);
      begin
        repeat (20) @(negedge clock);
        calPin = 1'b1;
      end
    join
    check(96'(resultCorrupt), 96'(1), "late request");
    close_out();
  end
endmodule
`default_nettype wire
